/* File: core/dsa_defs.vh */
/*
 * constants for the data space access unit: address map, page layout,
 * byte-operation codes.
 * assumes a 16-bit core with byte-granular effective addresses.
 */
`ifndef DSA_DEFS_VH
`define DSA_DEFS_VH

// ----------------------------------------------------------------
// address map
// ----------------------------------------------------------------
`define DSA_EA_W 16
`define DSA_PAGE_W 8
`define DSA_XADDR_W 24
`define DSA_DATA_W 16
`define DSA_SFR_LAST 16'h0fff
`define DSA_NEAR_LAST 16'h1fff
`define DSA_NEAR_W 13
`define DSA_RAM_FIRST 16'h1000
`define DSA_RAM_LAST 16'hcfff
`define DSA_BASE_PAGE 8'h00
`define DSA_RAM_WORDS 24576
`define DSA_RAM_AW 15
`define DSA_SFR_WORDS 2048
`define DSA_SFR_AW 11
`define DSA_ZERO16 16'h0000
`define DSA_ZERO8 8'h00

// ----------------------------------------------------------------
// working-register operations and pointer steps
// ----------------------------------------------------------------
`define DSA_WOP_NONE 2'h0
`define DSA_WOP_SIGN 2'h1
`define DSA_WOP_ZERO 2'h2
`define DSA_STEP_BYTE 16'h0001
`define DSA_STEP_WORD 16'h0002

`endif

/* File: core/dsa_ram.v */
/*
 * byte-laned data memory: separate read and write word addresses, two write strobes,
 * registered read word.
 * assumes the caller decodes range and alignment.
 */
`timescale 1ns/1ns
`include "dsa_defs.vh"
module dsa_ram #(
   parameter WORDS = `DSA_RAM_WORDS,
   parameter AW = `DSA_RAM_AW
) (
   input wire clock,
   input wire [AW-1:0] rd_word,
   input wire [AW-1:0] wr_word,
   input wire [1:0] wr_lane,
   input wire [`DSA_DATA_W-1:0] wr_data,
   output reg [`DSA_DATA_W-1:0] rd_data_q
);
   reg [7:0] lo_mem [0:WORDS-1];
   reg [7:0] hi_mem [0:WORDS-1];

   // ----------------------------------------------------------------
   // two parallel byte halves
   // ----------------------------------------------------------------
   always @(posedge clock) begin
      if (wr_lane[0]) begin
         lo_mem[wr_word] <= wr_data[7:0];
      end
      if (wr_lane[1]) begin
         hi_mem[wr_word] <= wr_data[15:8];
      end
      rd_data_q <= {hi_mem[rd_word], lo_mem[rd_word]};
   end
endmodule

/* File: core/dsa_wreg.v */
/*
 * working-register byte handling: byte load into low lane, sign and
 * zero extension of the low byte.
 * assumes the core supplies the current register value.
 */
`timescale 1ns/1ns
`include "dsa_defs.vh"
module dsa_wreg (
   input wire [`DSA_DATA_W-1:0] wreg_in,
   input wire [`DSA_DATA_W-1:0] load_data,
   input wire load_en,
   input wire load_byte,
   input wire [1:0] ext_op,
   output reg [`DSA_DATA_W-1:0] wreg_out
);
   // ----------------------------------------------------------------
   // result selection
   // ----------------------------------------------------------------
   always @* begin
      wreg_out = wreg_in;
      if (load_en && load_byte) begin
         wreg_out = {wreg_in[15:8], load_data[7:0]};
      end else if (load_en) begin
         wreg_out = load_data;
      end else begin
         case (ext_op)
            `DSA_WOP_SIGN: wreg_out = {{8{wreg_in[7]}}, wreg_in[7:0]};
            `DSA_WOP_ZERO: wreg_out = {`DSA_ZERO8, wreg_in[7:0]};
            default: wreg_out = wreg_in;
         endcase
      end
   end
endmodule

/* File: core/dsa_top.v */
/*
 * data space access unit: separate read and write address paths with
 * page extension, sfr and ram regions, zero fill, byte lanes,
 * misalignment trap, working-register byte operations.
 * assumes requests come from core logic on the same clock, one read and
 * one write per cycle at most, and sfr data is supplied combinationally
 * by the peripherals for the read address of the current request.
 */
`timescale 1ns/1ns
`include "dsa_defs.vh"
// Notes on behaviour
// - data space is 16 bits wide; byte addresses span 64 Kbytes, 32K words.
// - reads use read page, writes use write page, giving 16 Mbytes.
// - 4K sfr plus 48K ram implemented; other locations read zero.
// - low byte at even address, high byte at odd address.
// - post-increment pointer steps one for bytes, two for words.
// - byte read fetches the word, selects by bit 0, returns on low lane.
// - two byte halves share word decode; byte write strobes one half.
// - word access needs even address; misaligned word raises address trap.
// - misaligned read still completes the instruction before trapping; here data returns with the trap and the working register is not loaded.
// - misaligned write executes but the store is suppressed.
// - trap then entered, machine state kept as before the fault.
// - byte load into working register changes only the low byte.
// - sign extend turns 8-bit signed into 16-bit signed.
// - zero extend clears the high byte of the working register.
// - bytes 0x0000 to 0x0FFF hold special function registers.
// - unused special function register addresses read zero.
// - near region 0x0000 to 0x1FFF reachable by 13-bit direct field.
// - whole space reachable by 16-bit direct field or register pointer.
// - read and write addresses formed by independent generators.
module dsa_top (
   input wire clock,
   input wire rst_n,
   // read address generation unit
   input wire rd_req,
   input wire rd_byte,
   input wire [1:0] rd_mode,
   input wire [`DSA_EA_W-1:0] rd_direct,
   input wire [`DSA_EA_W-1:0] rd_pointer,
   // write address generation unit
   input wire wr_req,
   input wire wr_byte,
   input wire [1:0] wr_mode,
   input wire [`DSA_EA_W-1:0] wr_direct,
   input wire [`DSA_EA_W-1:0] wr_pointer,
   input wire [`DSA_DATA_W-1:0] wr_data,
   // page registers
   input wire rd_page_load,
   input wire wr_page_load,
   input wire [`DSA_PAGE_W-1:0] page_data,
   // special function register side
   input wire [`DSA_DATA_W-1:0] sfr_rd_data,
   input wire sfr_rd_hit,
   output reg [`DSA_SFR_AW-1:0] sfr_word_q,
   output reg [1:0] sfr_wr_lane_q,
   output reg [`DSA_DATA_W-1:0] sfr_wr_data_q,
   // working-register path
   input wire [`DSA_DATA_W-1:0] wreg_in,
   input wire wreg_load,
   input wire [1:0] ext_op,
   output reg [`DSA_DATA_W-1:0] wreg_out_q,
   // results
   output reg rd_valid_q,
   output reg [`DSA_DATA_W-1:0] rd_data_q,
   output reg [`DSA_XADDR_W-1:0] rd_xaddr_q,
   output reg [`DSA_XADDR_W-1:0] wr_xaddr_q,
   output reg [`DSA_EA_W-1:0] rd_pointer_next_q,
   output reg [`DSA_EA_W-1:0] wr_pointer_next_q,
   output reg wr_done_q,
   output reg addr_trap_q,
   output reg [`DSA_PAGE_W-1:0] read_page_register_q,
   output reg [`DSA_PAGE_W-1:0] write_page_register_q
);
   // ----------------------------------------------------------------
   // addressing modes
   // ----------------------------------------------------------------
   localparam MODE_NEAR = 2'h0;
   localparam MODE_DIRECT = 2'h1;
   localparam MODE_IND = 2'h2;
   localparam MODE_IND_INC = 2'h3;

   // decode region of a base address
   function is_sfr;
      input [`DSA_EA_W-1:0] ea;
      begin
         is_sfr = (ea <= `DSA_SFR_LAST);
      end
   endfunction

   function is_ram;
      input [`DSA_EA_W-1:0] ea;
      begin
         is_ram = (ea >= `DSA_RAM_FIRST) && (ea <= `DSA_RAM_LAST);
      end
   endfunction

   // effective address per generator, shared by both units
   function [`DSA_EA_W-1:0] form_ea;
      input [1:0] mode;
      input [`DSA_EA_W-1:0] direct;
      input [`DSA_EA_W-1:0] pointer;
      begin
         case (mode)
            MODE_NEAR: form_ea = {3'h0, direct[`DSA_NEAR_W-1:0]};
            MODE_DIRECT: form_ea = direct;
            MODE_IND: form_ea = pointer;
            MODE_IND_INC: form_ea = pointer;
            default: form_ea = pointer;
         endcase
      end
   endfunction

   function [`DSA_EA_W-1:0] step_ptr;
      input [1:0] mode;
      input byte_op;
      input [`DSA_EA_W-1:0] pointer;
      begin
         if (mode == MODE_IND_INC) begin
            step_ptr = pointer + (byte_op ? `DSA_STEP_BYTE : `DSA_STEP_WORD);
         end else begin
            step_ptr = pointer;
         end
      end
   endfunction

   // ----------------------------------------------------------------
   // independent read and write address generation
   // ----------------------------------------------------------------
   wire [`DSA_EA_W-1:0] rd_ea = form_ea(rd_mode, rd_direct, rd_pointer);
   wire [`DSA_EA_W-1:0] wr_ea = form_ea(wr_mode, wr_direct, wr_pointer);
   wire rd_mis = rd_req && !rd_byte && rd_ea[0];
   wire wr_mis = wr_req && !wr_byte && wr_ea[0];
   // only page zero maps onto implemented storage; other pages read zero
   wire rd_base = (read_page_register_q == `DSA_BASE_PAGE);
   wire wr_base = (write_page_register_q == `DSA_BASE_PAGE);
   wire rd_ram = rd_base && is_ram(rd_ea);
   wire rd_sfr = rd_base && is_sfr(rd_ea);
   wire wr_ok = wr_req && !wr_mis && wr_base;
   wire wr_ram = wr_ok && is_ram(wr_ea);
   wire wr_sfr = wr_ok && is_sfr(wr_ea);
   // byte lanes: even address is low half, odd is high half
   wire [1:0] wr_lane = wr_byte ? (wr_ea[0] ? 2'h2 : 2'h1) : 2'h3;
   wire [`DSA_DATA_W-1:0] wr_word_data = wr_byte ? {wr_data[7:0], wr_data[7:0]} : wr_data;
   // ram words counted from the first ram byte; that byte is even, so bit 0 stays the lane select
   wire [`DSA_EA_W-1:0] rd_ram_off = rd_ea - `DSA_RAM_FIRST;
   wire [`DSA_EA_W-1:0] wr_ram_off = wr_ea - `DSA_RAM_FIRST;
   wire [`DSA_RAM_AW-1:0] rd_ram_word = rd_ram_off[`DSA_RAM_AW:1];
   wire [`DSA_RAM_AW-1:0] wr_ram_word = wr_ram_off[`DSA_RAM_AW:1];
   wire [`DSA_DATA_W-1:0] ram_rd_word;
   wire [`DSA_DATA_W-1:0] wreg_next;
   // read pipeline and last-read state
   reg stage_valid_q;
   reg stage_byte_q;
   reg stage_odd_q;
   reg stage_ram_q;
   reg stage_sfr_q;
   reg stage_mis_q;
   reg [`DSA_DATA_W-1:0] stage_sfr_q_data;
   reg [`DSA_DATA_W-1:0] word_d;
   reg [`DSA_DATA_W-1:0] rd_data_d;
   reg last_byte_q;
   reg last_mis_q;

   // ----------------------------------------------------------------
   // storage and working-register helpers
   // ----------------------------------------------------------------
   dsa_ram #(
      .WORDS(`DSA_RAM_WORDS),
      .AW(`DSA_RAM_AW)
   ) u_ram (
      .clock(clock),
      .rd_word(rd_ram_word),
      .wr_word(wr_ram_word),
      .wr_lane(wr_ram ? wr_lane : 2'h0),
      .wr_data(wr_word_data),
      .rd_data_q(ram_rd_word)
   );

   dsa_wreg u_wreg (
      .wreg_in(wreg_in),
      .load_data(rd_data_q),
      .load_en(wreg_load),
      .load_byte(last_byte_q),
      .ext_op(ext_op),
      .wreg_out(wreg_next)
   );

   // ----------------------------------------------------------------
   // read pipeline: stage one captures decode, stage two returns data
   // ----------------------------------------------------------------
   // unmapped or off-page reads fall through to zero
   always @* begin
      word_d = `DSA_ZERO16;
      if (stage_ram_q) begin
         word_d = ram_rd_word;
      end else if (stage_sfr_q) begin
         word_d = stage_sfr_q_data;
      end
      if (stage_byte_q) begin
         rd_data_d = {`DSA_ZERO8, stage_odd_q ? word_d[15:8] : word_d[7:0]};
      end else begin
         rd_data_d = word_d;
      end
   end

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         stage_valid_q <= 1'b0;
         stage_byte_q <= 1'b0;
         stage_odd_q <= 1'b0;
         stage_ram_q <= 1'b0;
         stage_sfr_q <= 1'b0;
         stage_mis_q <= 1'b0;
         stage_sfr_q_data <= `DSA_ZERO16;
         rd_xaddr_q <= {`DSA_XADDR_W{1'b0}};
         rd_pointer_next_q <= `DSA_ZERO16;
      end else begin
         stage_valid_q <= rd_req;
         stage_byte_q <= rd_byte;
         stage_odd_q <= rd_ea[0];
         stage_ram_q <= rd_req && rd_ram;
         stage_sfr_q <= rd_req && rd_sfr;
         stage_mis_q <= rd_mis;
         // unused sfr locations answer zero
         stage_sfr_q_data <= sfr_rd_hit ? sfr_rd_data : `DSA_ZERO16;
         if (rd_req) begin
            rd_xaddr_q <= {read_page_register_q, rd_ea};
            rd_pointer_next_q <= step_ptr(rd_mode, rd_byte, rd_pointer);
         end
      end
   end

   // ----------------------------------------------------------------
   // last read: data and its flags stand until the next answer
   // ----------------------------------------------------------------
   // held so a later byte load still sees the read it belongs to
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rd_valid_q <= 1'b0;
         rd_data_q <= `DSA_ZERO16;
         last_byte_q <= 1'b0;
         last_mis_q <= 1'b0;
      end else begin
         // a misaligned read still returns its data; the trap is raised in the same cycle
         rd_valid_q <= stage_valid_q;
         if (stage_valid_q) begin
            rd_data_q <= rd_data_d;
            last_byte_q <= stage_byte_q;
            last_mis_q <= stage_mis_q;
         end
      end
   end

   // ----------------------------------------------------------------
   // write side, page registers, trap
   // ----------------------------------------------------------------
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         read_page_register_q <= `DSA_BASE_PAGE;
         write_page_register_q <= `DSA_BASE_PAGE;
         sfr_word_q <= {`DSA_SFR_AW{1'b0}};
         sfr_wr_lane_q <= 2'h0;
         sfr_wr_data_q <= `DSA_ZERO16;
         wr_xaddr_q <= {`DSA_XADDR_W{1'b0}};
         wr_pointer_next_q <= `DSA_ZERO16;
         wr_done_q <= 1'b0;
         addr_trap_q <= 1'b0;
      end else begin
         // pages change only on their own load pulse
         if (rd_page_load) begin
            read_page_register_q <= page_data;
         end
         if (wr_page_load) begin
            write_page_register_q <= page_data;
         end
         sfr_word_q <= wr_sfr ? wr_ea[`DSA_SFR_AW:1] : rd_ea[`DSA_SFR_AW:1];
         sfr_wr_lane_q <= wr_sfr ? wr_lane : 2'h0;
         sfr_wr_data_q <= wr_word_data;
         wr_done_q <= wr_req;
         if (wr_req) begin
            wr_xaddr_q <= {write_page_register_q, wr_ea};
            wr_pointer_next_q <= step_ptr(wr_mode, wr_byte, wr_pointer);
         end
         // write trap is raised with the suppressed write; read trap once the data has returned
         addr_trap_q <= wr_mis || (stage_valid_q && stage_mis_q);
      end
   end

   // ----------------------------------------------------------------
   // working-register result
   // ----------------------------------------------------------------
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         wreg_out_q <= `DSA_ZERO16;
      end else begin
         // the working register is not updated by the faulting read
         if (!(wreg_load && last_mis_q)) begin
            wreg_out_q <= wreg_next;
         end
      end
   end
endmodule

/* File: test/dsa_monitor.sv */
/* port checker for dsa_top.
   assumes one clock domain and an async active-low reset. */
`timescale 1ns/1ns
module dsa_monitor (
   input wire clock,
   input wire rst_n,
   input wire rd_req,
   input wire rd_byte,
   input wire [1:0] rd_mode,
   input wire [15:0] rd_direct,
   input wire wr_req,
   input wire wr_byte,
   input wire [1:0] wr_mode,
   input wire [15:0] wr_direct,
   input wire [15:0] wr_pointer,
   input wire [15:0] wreg_in,
   input wire wreg_load,
   input wire [1:0] ext_op,
   input wire [15:0] wreg_out_q,
   input wire rd_valid_q,
   input wire [15:0] rd_data_q,
   input wire [23:0] wr_xaddr_q,
   input wire [15:0] wr_pointer_next_q,
   input wire wr_done_q,
   input wire addr_trap_q,
   input wire [1:0] sfr_wr_lane_q,
   input wire [7:0] write_page_register_q
);
   // ----------------------------------------
   // properties
   // ----------------------------------------
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   a_read_latency: assert property (rd_req |-> ##2 rd_valid_q) else $error("read answer late");
   a_valid_cause: assert property (rd_valid_q |-> $past(rd_req, 2)) else $error("read answer unasked");
   a_byte_lane_low: assert property (rd_req && rd_byte |-> ##2 rd_data_q[15:8] == 8'h00) else $error("byte high lane");
   a_wr_trap: assert property (wr_req && !wr_byte && wr_mode == 2'h1 && wr_direct[0]
      |=> addr_trap_q && wr_done_q) else $error("misaligned write not trapped");
   a_store_blocked: assert property (wr_req && !wr_byte && wr_mode == 2'h1 && wr_direct[0]
      |=> sfr_wr_lane_q == 2'h0) else $error("misaligned write stored");
   a_rd_trap: assert property (rd_req && !rd_byte && rd_mode == 2'h1 && rd_direct[0]
      |-> ##2 rd_valid_q && addr_trap_q) else $error("misaligned read trap");
   a_wr_xaddr: assert property (wr_req && wr_mode == 2'h1 && !$past(wr_req)
      |=> wr_xaddr_q == {$past(write_page_register_q), $past(wr_direct)}) else $error("write page wrong");
   a_ptr_step: assert property (wr_req && wr_mode == 2'h3
      |=> wr_pointer_next_q == $past(wr_pointer) + ($past(wr_byte) ? 16'h0001 : 16'h0002)) else $error("step");
   a_sign_ext: assert property (ext_op == 2'h1 && !wreg_load
      |=> wreg_out_q == {{8{$past(wreg_in[7])}}, $past(wreg_in[7:0])}) else $error("sign extend");
   a_zero_ext: assert property (ext_op == 2'h2 && !wreg_load
      |=> wreg_out_q == {8'h00, $past(wreg_in[7:0])}) else $error("zero extend");
endmodule
bind dsa_top dsa_monitor mon (.clock, .rst_n, .rd_req, .rd_byte, .rd_mode, .rd_direct, .wr_req, .wr_byte,
   .wr_mode, .wr_direct, .wr_pointer, .wreg_in, .wreg_load, .ext_op, .wreg_out_q, .rd_valid_q, .rd_data_q,
   .wr_xaddr_q, .wr_pointer_next_q, .wr_done_q, .addr_trap_q, .sfr_wr_lane_q, .write_page_register_q);

/* File: test/dsa_sfr_model.sv */
/* peripheral side: one implemented special register word.
   assumes the read address is the direct field of the request. */
`timescale 1ns/1ns
module dsa_sfr_model #(
   parameter [10:0] IMPL = 11'h080
) (
   input wire clock,
   input wire rst_n,
   input wire [15:0] rd_ea,
   input wire [10:0] sfr_word_q,
   input wire [1:0] sfr_wr_lane_q,
   input wire [15:0] sfr_wr_data_q,
   output wire [15:0] sfr_rd_data,
   output wire sfr_rd_hit
);
   reg [15:0] store_q;
   assign sfr_rd_hit = rd_ea[15:12] == 4'h0 && rd_ea[11:1] == IMPL;
   // not selected: inverse value, so a missing zero fill shows
   assign sfr_rd_data = sfr_rd_hit ? store_q : ~store_q;
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         store_q <= 16'h0000;
      end else if (sfr_word_q == IMPL) begin
         if (sfr_wr_lane_q[0]) store_q[7:0] <= sfr_wr_data_q[7:0];
         if (sfr_wr_lane_q[1]) store_q[15:8] <= sfr_wr_data_q[15:8];
      end
   end
endmodule

/* File: test/testbench.sv */
/* self-checking bench for dsa_top.
   assumes the sfr model and the bound checker. */
`timescale 1ns/1ns
module testbench;
   reg clock, rst_n, rd_req, rd_byte, wr_req, wr_byte, rd_page_load, wr_page_load, wreg_load;
   reg [1:0] rd_mode, wr_mode, ext_op;
   reg [15:0] rd_direct, rd_pointer, wr_direct, wr_pointer, wr_data, wreg_in, d;
   reg [7:0] page_data;
   reg v, t, dn;
   reg [1:0] ln;
   wire [15:0] sfr_rd_data, sfr_wr_data_q, wreg_out_q, rd_data_q, rd_pointer_next_q, wr_pointer_next_q;
   wire [10:0] sfr_word_q;
   wire [1:0] sfr_wr_lane_q;
   wire [23:0] rd_xaddr_q, wr_xaddr_q;
   wire [7:0] read_page_register_q, write_page_register_q;
   wire sfr_rd_hit, rd_valid_q, wr_done_q, addr_trap_q;
   integer failures, compares;
   dsa_top uut (.clock, .rst_n, .rd_req, .rd_byte, .rd_mode, .rd_direct, .rd_pointer, .wr_req, .wr_byte,
      .wr_mode, .wr_direct, .wr_pointer, .wr_data, .rd_page_load, .wr_page_load, .page_data, .sfr_rd_data,
      .sfr_rd_hit, .sfr_word_q, .sfr_wr_lane_q, .sfr_wr_data_q, .wreg_in, .wreg_load, .ext_op, .wreg_out_q,
      .rd_valid_q, .rd_data_q, .rd_xaddr_q, .wr_xaddr_q, .rd_pointer_next_q, .wr_pointer_next_q, .wr_done_q,
      .addr_trap_q, .read_page_register_q, .write_page_register_q);
   dsa_sfr_model sfr (.clock, .rst_n, .rd_ea(rd_direct), .sfr_word_q, .sfr_wr_lane_q, .sfr_wr_data_q,
      .sfr_rd_data, .sfr_rd_hit);
   // ----------------------------------------
   // bus tasks
   // ----------------------------------------
   task chk(input [23:0] got, input [23:0] exp);
      begin
         compares = compares + 1;
         if (got !== exp) begin
            failures = failures + 1;
            $display("BAD %0t got %h want %h", $time, got, exp);
         end
      end
   endtask
   task rd(input [1:0] m, input b, input [15:0] a);
      integer i;
      begin
         @(posedge clock);
         rd_req <= 1'b1;
         rd_byte <= b;
         rd_mode <= m;
         rd_direct <= a;
         rd_pointer <= a;
         @(posedge clock);
         rd_req <= 1'b0;
         v = 1'b0;
         // bounded wait on the answer pulse
         for (i = 0; i < 4 && v !== 1'b1; i = i + 1) begin
            @(posedge clock);
            #1 v = rd_valid_q;
         end
         d = rd_data_q;
         t = addr_trap_q;
      end
   endtask
   task wr(input [1:0] m, input b, input [15:0] a, input [15:0] x);
      begin
         @(posedge clock);
         wr_req <= 1'b1;
         wr_byte <= b;
         wr_mode <= m;
         wr_direct <= a;
         wr_pointer <= a;
         wr_data <= x;
         @(posedge clock);
         wr_req <= 1'b0;
         #1 dn = wr_done_q;
         t = addr_trap_q;
         ln = sfr_wr_lane_q;
      end
   endtask
   task pg(input r, input [7:0] p);
      begin
         @(posedge clock);
         rd_page_load <= r;
         wr_page_load <= !r;
         page_data <= p;
         @(posedge clock);
         rd_page_load <= 1'b0;
         wr_page_load <= 1'b0;
      end
   endtask
   task wop(input l, input [1:0] e, input [15:0] w);
      begin
         @(posedge clock);
         wreg_load <= l;
         ext_op <= e;
         wreg_in <= w;
         @(posedge clock);
         wreg_load <= 1'b0;
         ext_op <= 2'h0;
         #1;
      end
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task t_ram;
      begin
         wr(2'h1, 0, 16'h1000, 16'h1234);
         rd(2'h1, 0, 16'h1000);
         chk(d, 16'h1234);
         rd(2'h2, 1, 16'h1000);
         chk(d, 16'h0034);
         rd(2'h1, 1, 16'h1001);
         chk(d, 16'h0012);
         wr(2'h1, 1, 16'h1001, 16'h00ab);
         rd(2'h0, 0, 16'hf000);
         chk(d, 16'hab34);
         rd(2'h3, 1, 16'h1000);
         chk(rd_pointer_next_q, 16'h1001);
         wr(2'h3, 0, 16'h1000, 16'hab34);
         chk(wr_pointer_next_q, 16'h1002);
         $display("test ram done");
      end
   endtask
   task t_mis;
      begin
         wr(2'h1, 0, 16'h1002, 16'h5a5a);
         wr(2'h1, 0, 16'h1003, 16'hffff);
         chk({dn, t}, 2'h3);
         rd(2'h1, 0, 16'h1001);
         chk({v, t}, 2'h3);
         rd(2'h1, 0, 16'h1002);
         chk({t, d}, 16'h5a5a);
         $display("test misaligned done");
      end
   endtask
   task t_map;
      begin
         wr(2'h1, 0, 16'hd000, 16'h1111);
         rd(2'h1, 0, 16'hd000);
         chk(d, 16'h0000);
         pg(0, 8'h01);
         wr(2'h1, 0, 16'h1000, 16'h7777);
         chk(wr_xaddr_q, 24'h011000);
         chk(write_page_register_q, 24'h000001);
         pg(0, 8'h00);
         pg(1, 8'h01);
         rd(2'h1, 0, 16'h1000);
         chk({rd_xaddr_q[23:16], d}, 24'h010000);
         chk(read_page_register_q, 24'h000001);
         pg(1, 8'h00);
         rd(2'h1, 0, 16'h1000);
         chk(d, 16'hab34);
         $display("test map done");
      end
   endtask
   task t_sfr;
      begin
         wr(2'h1, 0, 16'h0100, 16'hbeef);
         chk(ln, 2'h3);
         wr(2'h1, 1, 16'h0101, 16'h0011);
         chk(ln, 2'h2);
         rd(2'h1, 0, 16'h0100);
         chk(d, 16'h11ef);
         rd(2'h1, 0, 16'h0200);
         chk(d, 16'h0000);
         $display("test sfr done");
      end
   endtask
   task t_wreg;
      begin
         wop(0, 2'h1, 16'h0080);
         chk(wreg_out_q, 16'hff80);
         wop(0, 2'h2, 16'hff80);
         chk(wreg_out_q, 16'h0080);
         rd(2'h1, 1, 16'h1001);
         wop(1, 2'h0, 16'h5555);
         chk(wreg_out_q, 16'h55ab);
         $display("test wreg done");
      end
   endtask
   task finish_test;
      begin
         $display("counts: %0d compares, %0d failures", compares, failures);
         if (failures == 0 && compares > 0)
            $display("Finished cleanly");
         else
            $display("Finished with errors");
         $finish;
      end
   endtask
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   initial begin
      // about 80 cycles of work; generous margin
      #100000;
      failures = failures + 1;
      finish_test;
   end
   initial begin
      {rd_req, rd_byte, wr_req, wr_byte, rd_page_load, wr_page_load, wreg_load} = 7'h00;
      {rd_mode, wr_mode, ext_op, page_data} = 14'h0000;
      {rd_direct, rd_pointer, wr_direct, wr_pointer, wr_data, wreg_in} = 96'h0;
      failures = 0;
      compares = 0;
      rst_n = 1'b0;
      repeat (5) @(posedge clock);
      rst_n <= 1'b1;
      t_ram;
      t_mis;
      t_map;
      t_sfr;
      t_wreg;
      finish_test;
   end
endmodule
